/* File: spi_lp_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package spi_lp_pkg;

  // --------------------------------------------------------------------
  // Register word offsets (byte addresses, one aligned word each)
  // --------------------------------------------------------------------
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_CSR = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;

  // --------------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------------
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_PORT_EN = 6;
  localparam int CTL_DIV2 = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLK_IDLE_LEVEL = 3;
  localparam int CTL_CLK_SAMPLE_PHASE = 2;
  localparam int CTL_DIV1 = 1;
  localparam int CTL_DIV0 = 0;
  localparam logic [3:0] CTL_TOP_RESET = 4'h0;
  localparam logic [3:0] CTL_LOW_RESET = 4'h0;

  // --------------------------------------------------------------------
  // Control/status register fields
  // --------------------------------------------------------------------
  localparam int CSR_DONE = 7;
  localparam int CSR_CLASH = 6;
  localparam int CSR_OVR = 5;
  localparam int CSR_FAULT = 4;
  localparam int CSR_OUT_DIS = 2;
  localparam int CSR_SSM = 1;
  localparam int CSR_SSI = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // --------------------------------------------------------------------
  // Serial engine constants
  // --------------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_COUNT = 4'h8;
  localparam logic [6:0] HALF_DIV_RESET = 7'h01;
  // Half period of the master clock in CPU cycles, per divide ratio
  localparam logic [6:0] HALF_DIV_4 = 7'h02;
  localparam logic [6:0] HALF_DIV_8 = 7'h04;
  localparam logic [6:0] HALF_DIV_16 = 7'h08;
  localparam logic [6:0] HALF_DIV_32 = 7'h10;
  localparam logic [6:0] HALF_DIV_64 = 7'h20;
  localparam logic [6:0] HALF_DIV_128 = 7'h40;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_RUN = 2'b01,
    XFER_DONE = 2'b11
  } xfer_state_t;

endpackage

/* File: spi_ctrl_lowpower.sv */
// Serial peripheral: control, status, low-power and byte shifter
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - Wait mode leaves the interface running; done, fault or overrun wakes.
// - Halt freezes registers and serial activity, except a slave selected at halt entry, until an interrupt wakes.
// - As slave, done may exit halt; fault and overrun only exit wait.
// - More than one completed byte before done is cleared sets overrun.
// - Halt wake only if effective slave select was low at halt entry.
// - One interrupt if enable set, mask clear, done/fault/overrun set.
// - Control bits: irq enable, port, div2, master, clk_idle_level, clk_sample_phase, div1:0.
// - Port enable cleared by reset and by select low in master mode.
// - Master bit cleared by select low in master; master drives clock out.
// - Master divide by div bits: 100/4 000/8 001/16 110/32 010/64 011/128.
// - Divider bits have no effect in slave mode; clock comes from master.
// - Clock polarity sets idle clock level in both modes.
// - Phase 0 captures on first clock edge, phase 1 on second.
// - Status resets to zero: done, clash, ovr, fault, 0, od, ssm, ssi.
// - Done set on byte end; cleared by status access then data access.
// - Data writes ignored while done is set until status is accessed.
// - Data write mid-transfer sets clash; transfer goes on, write dropped.
// - Overrun set on byte end while done set; status read clears it.
// - Select low as master sets fault; access then control write clears.
// - Output disable bit turns off MOSI as master or MISO as slave.
// - Select management bit chooses internal select bit instead of pin.
// - Internal select bit: 0 selects slave, 1 deselects.
// - Data write loads 8-bit shifter, sent most significant bit first.
module spi_ctrl_lowpower
  import spi_lp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Processor power state and interrupt mask
  input wire logic cpuHalt,
  input wire logic cpuWait,
  input wire logic cpuIrqMask,
  output logic irqRequest,
  output logic wakeFromWait,
  output logic wakeFromHalt,
  // Serial pins
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic selectInN,
  output logic portEnable
);

  // ------------------------------------------------------------------
  // Registers and internal state
  // ------------------------------------------------------------------
  logic [7:0] ctrl;
  logic doneFlag, clashFlag, ovrFlag, faultFlag;
  logic outDisable, softManage, softLevel;
  logic [7:0] shiftReg, rxBuf;
  logic [3:0] bitCnt;
  logic [6:0] divCnt;
  logic sckInt, sckPrev;
  logic csrSeen, faultSeen, clashSeen;
  logic selectHaltN, accessPhase, halfDone;
  xfer_state_t state;

  // Decoded bus strobes; every access answers in its second cycle
  logic rdStb, wrStb, wrLow;
  assign rdStb = read & accessPhase;
  assign wrStb = write & accessPhase;
  assign wrLow = wrStb & byteenable[0];

  // Effective select level, low means selected
  logic selectN;
  assign selectN = softManage ? softLevel : selectInN;

  logic master, running, modeFault, frozen;
  assign master = ctrl[CTL_MASTER];
  assign running = (state == XFER_RUN);
  // Halt freezes all but a slave selected at halt entry, which keeps
  // receiving so that a finished byte can wake the processor
  logic haltListen;
  assign haltListen = ~master & ctrl[CTL_PORT_EN] &
                      (halfDone ? ~selectHaltN : ~selectN);
  assign frozen = cpuHalt & ~haltListen;
  assign modeFault = master & ~selectN & ctrl[CTL_PORT_EN];

  // Half period of master clock in CPU cycles
  logic [6:0] halfDiv;
  always_comb begin
    unique case ({ctrl[CTL_DIV2], ctrl[CTL_DIV1], ctrl[CTL_DIV0]})
      3'b100: halfDiv = HALF_DIV_4;
      3'b000: halfDiv = HALF_DIV_8;
      3'b001: halfDiv = HALF_DIV_16;
      3'b110: halfDiv = HALF_DIV_32;
      3'b010: halfDiv = HALF_DIV_64;
      3'b011: halfDiv = HALF_DIV_128;
      default: halfDiv = HALF_DIV_128;
    endcase
  end

  // ------------------------------------------------------------------
  // Bus handshake: waitrequest high for first cycle of each request
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      accessPhase <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      accessPhase <= (read | write) & ~accessPhase;
      waitrequest <= ~((read | write) & ~accessPhase);
    end
  end

  // Read data
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if ((read | write) & ~accessPhase & read) begin
      unique case (address)
        OFS_DATA: readdata <= {24'h0, rxBuf};
        OFS_CTRL: readdata <= {24'h0, ctrl};
        // Reserved bit 3 always reads zero
        OFS_CSR: readdata <= {24'h0, doneFlag, clashFlag, ovrFlag, faultFlag,
                              1'b0, outDisable, softManage, softLevel};
        OFS_STAT: readdata <= {29'h0, state == XFER_RUN, selectHaltN, frozen};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Control register with hardware clear on mode fault
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= {CTL_TOP_RESET, CTL_LOW_RESET};
    end else if (!frozen) begin
      if (modeFault) begin
        ctrl[CTL_PORT_EN] <= 1'b0;
        ctrl[CTL_MASTER] <= 1'b0;
      end else if (wrLow && address == OFS_CTRL) begin
        ctrl <= writedata[7:0];
        // Port and master stay clear while fault is pending
        if (faultFlag && !faultSeen) begin
          ctrl[CTL_PORT_EN] <= 1'b0;
          ctrl[CTL_MASTER] <= 1'b0;
        end
      end
    end
  end

  // Control/status software bits
  always_ff @(posedge clock) begin
    if (rst) begin
      outDisable <= CSR_RESET[CSR_OUT_DIS];
      softManage <= CSR_RESET[CSR_SSM];
      softLevel <= CSR_RESET[CSR_SSI];
    end else if (!frozen && wrLow && address == OFS_CSR) begin
      outDisable <= writedata[CSR_OUT_DIS];
      softManage <= writedata[CSR_SSM];
      softLevel <= writedata[CSR_SSI];
    end
  end

  // ------------------------------------------------------------------
  // Serial engine: shift, clock generation and sampling
  // ------------------------------------------------------------------
  logic edgeNow, leadEdge, sampleEdge, slaveSel, doneEvt;
  logic nextSck;
  assign slaveSel = ~master & ~selectN & ctrl[CTL_PORT_EN];
  // Master toggles internal clock; slave watches pin
  assign nextSck = master ? sckInt : sckIn;
  assign edgeNow = running & (nextSck != sckPrev);
  // Leading edge leaves idle level
  assign leadEdge = edgeNow & (nextSck != ctrl[CTL_CLK_IDLE_LEVEL]);
  // Capture edge: first when phase 0, second when phase 1
  assign sampleEdge = edgeNow & (leadEdge ^ ctrl[CTL_CLK_SAMPLE_PHASE]);
  assign doneEvt = sampleEdge & (bitCnt == 4'h1);

  logic dataIn, dataWr;
  assign dataIn = master ? misoIn : mosiIn;
  assign dataWr = wrLow && address == OFS_DATA;

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= XFER_IDLE;
      shiftReg <= 8'h0;
      bitCnt <= 4'h0;
      divCnt <= HALF_DIV_RESET;
      sckInt <= 1'b0;
      sckPrev <= 1'b0;
      rxBuf <= 8'h0;
    end else if (!frozen) begin
      sckPrev <= nextSck;
      unique case (state)
        XFER_IDLE: begin
          sckInt <= ctrl[CTL_CLK_IDLE_LEVEL];
          sckPrev <= master ? ctrl[CTL_CLK_IDLE_LEVEL] : sckIn;
          divCnt <= HALF_DIV_RESET;
          // Accepted write loads the shifter
          if (dataWr && !(doneFlag && !csrSeen)) begin
            shiftReg <= writedata[7:0];
            bitCnt <= BIT_COUNT;
            if (master && ctrl[CTL_PORT_EN]) begin
              state <= XFER_RUN;
            end
          end
          if (slaveSel) begin
            if (bitCnt == 4'h0) begin
              bitCnt <= BIT_COUNT;
            end
            state <= XFER_RUN;
          end
        end
        XFER_RUN: begin
          if (master) begin
            if (divCnt == halfDiv) begin
              divCnt <= HALF_DIV_RESET;
              sckInt <= ~sckInt;
            end else begin
              divCnt <= divCnt + 7'h01;
            end
          end
          if (sampleEdge) begin
            shiftReg <= {shiftReg[BYTE_BITS-2:0], dataIn}; // MSB first
            bitCnt <= bitCnt - 4'h1;
          end
          if (doneEvt) begin
            rxBuf <= {shiftReg[BYTE_BITS-2:0], dataIn};
            // Phase 1 ends on the idle level; phase 0 still owes an edge
            if (ctrl[CTL_CLK_SAMPLE_PHASE]) begin
              state <= XFER_DONE;
            end
          end else if (edgeNow && bitCnt == 4'h0) begin
            state <= XFER_DONE; // Last half period runs in full
          end
          if (!master && selectN) begin
            bitCnt <= 4'h0; // Drop a partial count so reselect starts fresh
            state <= XFER_IDLE; // Slave deselected mid-byte
          end
          if (!ctrl[CTL_PORT_EN]) begin
            state <= XFER_IDLE;
          end
        end
        XFER_DONE: begin
          // Return the clock to its idle level and clear the count, then idle
          sckInt <= ctrl[CTL_CLK_IDLE_LEVEL];
          bitCnt <= 4'h0;
          state <= XFER_IDLE;
        end
        default: state <= XFER_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Status flags; hardware set wins over software clear
  // ------------------------------------------------------------------
  logic csrAcc, csrRead, dataRead, ctrlWrite;
  assign csrAcc = (rdStb | wrStb) && address == OFS_CSR;
  assign csrRead = rdStb && address == OFS_CSR;
  assign dataRead = rdStb && address == OFS_DATA;
  assign ctrlWrite = wrStb && address == OFS_CTRL;

  always_ff @(posedge clock) begin
    if (rst) begin
      doneFlag <= CSR_RESET[CSR_DONE];
      csrSeen <= 1'b0;
    end else if (doneEvt && !frozen) begin
      doneFlag <= 1'b1;
      csrSeen <= 1'b0;
    end else if (doneFlag && csrAcc) begin
      csrSeen <= 1'b1;
    end else if (csrSeen && (dataRead || dataWr)) begin
      doneFlag <= 1'b0;
      csrSeen <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ovrFlag <= CSR_RESET[CSR_OVR];
    end else if (doneEvt && doneFlag && !frozen) begin
      ovrFlag <= 1'b1;
    end else if (csrRead) begin
      ovrFlag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clashFlag <= CSR_RESET[CSR_CLASH];
      clashSeen <= 1'b0;
    end else if (dataWr && running && !frozen) begin
      clashFlag <= 1'b1;
      clashSeen <= 1'b0;
    end else if (clashFlag && csrRead) begin
      clashSeen <= 1'b1;
    end else if (clashSeen && dataRead) begin
      clashFlag <= 1'b0;
      clashSeen <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      faultFlag <= CSR_RESET[CSR_FAULT];
      faultSeen <= 1'b0;
    end else if (modeFault && !frozen) begin
      faultFlag <= 1'b1;
      faultSeen <= 1'b0;
    end else if (faultFlag && (rdStb || wrStb) && !ctrlWrite) begin
      faultSeen <= 1'b1;
    end else if (faultSeen && ctrlWrite) begin
      faultFlag <= 1'b0;
      faultSeen <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request and wake-up outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      selectHaltN <= 1'b1;
      halfDone <= 1'b0;
    end else begin
      halfDone <= cpuHalt;
      // Capture select level on halt entry
      if (cpuHalt && !halfDone) begin
        selectHaltN <= selectN;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irqRequest <= 1'b0;
      wakeFromWait <= 1'b0;
      wakeFromHalt <= 1'b0;
    end else begin
      // Shared request; clash never contributes
      irqRequest <= ctrl[CTL_IRQ_EN] & ~cpuIrqMask &
                    (doneFlag | faultFlag | ovrFlag);
      // Done, fault or overrun ends wait; interface keeps running
      wakeFromWait <= cpuWait & ctrl[CTL_IRQ_EN] &
                      (doneFlag | faultFlag | ovrFlag);
      // Only slave done exits halt, if selected at entry
      wakeFromHalt <= cpuHalt & ctrl[CTL_IRQ_EN] & ~master &
                      ~selectHaltN & doneFlag;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      portEnable <= 1'b0;
    end else begin
      portEnable <= ctrl[CTL_PORT_EN];
      sckOut <= running ? sckInt : ctrl[CTL_CLK_IDLE_LEVEL];
      sckOe <= ctrl[CTL_PORT_EN] & master;
      mosiOut <= shiftReg[BYTE_BITS-1];
      misoOut <= shiftReg[BYTE_BITS-1];
      // Data output direction swaps with role
      mosiOe <= ctrl[CTL_PORT_EN] & master & ~outDisable;
      misoOe <= ctrl[CTL_PORT_EN] & ~master & ~outDisable & ~selectN;
    end
  end

endmodule

/* File: spi_ctrl_lowpower_checker.sv */
// Checker: port-level assertions for the serial control block
`timescale 1ns/1ps
module spi_ctrl_lowpower_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Power state and events
  input wire logic cpuHalt,
  input wire logic cpuWait,
  input wire logic cpuIrqMask,
  input wire logic irqRequest,
  input wire logic wakeFromWait,
  input wire logic wakeFromHalt,
  // Serial pins
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic portEnable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // Bus, interrupt, power and pin relations
  // --------------------------------------------------------------
  a_bus_answer: assert property ((read || write) && waitrequest
    |=> !waitrequest) else $error("bus answer not in second cycle");
  a_read_upper: assert property (read && !waitrequest
    |-> readdata[31:8] == 24'h0) else $error("upper read bits set");
  a_irq_mask: assert property (irqRequest
    |-> !$past(cpuIrqMask)) else $error("interrupt while masked");
  a_wait_wake: assert property (wakeFromWait
    |-> $past(cpuWait)) else $error("wait wake outside wait");
  a_halt_wake: assert property (wakeFromHalt
    |-> $past(cpuHalt) && !sckOe) else $error("halt wake wrong");
  a_halt_freeze: assert property ($past(cpuHalt, 2)
    && $past(cpuHalt) |-> $stable(sckOut)) else $error("clock moved");
  a_oe_port: assert property (mosiOe || misoOe || sckOe
    |-> portEnable || $past(portEnable)) else $error("pin driven");
  a_role_swap: assert property (misoOe
    |-> !mosiOe && !sckOe) else $error("both roles drive pins");
  a_sck_hold: assert property ($rose(sckOut) && sckOe
    |=> sckOut) else $error("serial clock half too short");
endmodule

/* File: spi_far_slave.sv */
// Far-side serial slave model for master-mode transfers
`timescale 1ns/1ps
module spi_far_slave (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  output logic miso,
  // Mode and data
  input wire logic clk_idle_level,
  input wire logic clk_sample_phase,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte
);
  int caps = 0;
  initial miso = 1'b0;
  // Selection presents the first reply bit
  always @(negedge selN) begin
    caps = 0;
    miso = txByte[7];
  end
  // Released line shows the inverse of its last value
  always @(posedge selN) begin
    miso = ~miso;
  end
  // Capture edge or shift edge by phase and polarity
  always @(sck) begin
    if (!selN && caps < 8) begin
      if ((sck != clk_idle_level) != clk_sample_phase) begin
        rxByte = {rxByte[6:0], mosi};
        caps++;
      end else begin
        miso = txByte[7 - caps];
      end
    end
  end
endmodule

/* File: tb_spi_ctrl_lowpower.sv */
// Testbench for the serial control and low-power block
`timescale 1ns/1ps
module tb_spi_ctrl_lowpower;
  import spi_lp_pkg::*;
  // Clock, reset, bus
  logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, irqRequest, wakeFromWait, wakeFromHalt;
  // Power state and pins
  logic cpuHalt = 1'b0, cpuWait = 1'b0, cpuIrqMask = 1'b0;
  logic sckIn = 1'b0, mosiIn = 1'b0, misoIn, selectInN = 1'b1;
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, portEnable;
  // Far side and bookkeeping
  logic farSelN = 1'b1, farCpol = 1'b0, farCpha = 1'b0;
  logic [7:0] farTx = 8'h00, farRx, rd;
  int errCount = 0, nTests = 0;

  spi_ctrl_lowpower spi_ctrl_lowpower_inst (.clock, .rst, .address,
    .read, .write, .writedata, .byteenable(4'h1), .readdata,
    .waitrequest, .cpuHalt, .cpuWait, .cpuIrqMask, .irqRequest,
    .wakeFromWait, .wakeFromHalt, .sckIn, .sckOut, .sckOe, .mosiIn,
    .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .selectInN,
    .portEnable);
  spi_far_slave spi_far_slave_inst (.sck(sckOut), .mosi(mosiOut),
    .selN(farSelN), .miso(misoIn), .clk_idle_level(farCpol), .clk_sample_phase(farCpha),
    .txByte(farTx), .rxByte(farRx));

  // 50 MHz clock
  initial forever #10 clock = ~clock;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus access held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [3:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        errCount++;
        stopTest();
      end
      @(posedge clock);
    end
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    // Let registered outputs that follow the write settle
    repeat (2) @(posedge clock);
  endtask

  // Bit-banged master byte, mode 0, sampling the slave reply
  task automatic slvByte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      mosiIn <= b[k];
      repeat (4) @(posedge clock);
      rd[k] = misoOut;
      sckIn <= 1'b1;
      repeat (4) @(posedge clock);
      sckIn <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic masterDivs();
    logic [2:0] dv[6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010,
                          3'b011};
    int n;
    bus(1, OFS_CSR, 8'h03);
    for (int i = 0; i < 6; i++) begin
      bus(1, OFS_CTRL, 8'h00);
      bus(1, OFS_CTRL, {2'b01, dv[i][2], 1'b1, i[1], i[0], dv[i][1:0]});
      chk(sckOut, i[1]);
      farCpol <= i[1];
      farCpha <= i[0];
      farTx <= 8'h3c + i[7:0];
      farSelN <= 1'b0;
      bus(1, OFS_DATA, 8'h96 ^ i[7:0]);
      for (int p = 0; p < 3; p++) begin
        n = 0;
        while ((sckOut === i[1]) == (p != 1) && n < 300) begin
          n++;
          @(posedge clock);
        end
        if (n >= 300) begin
          errCount++;
          stopTest();
        end
      end
      chk(n[7:0], 8'h02 << i);
      if (i == 5) bus(1, OFS_DATA, 8'hff);
      n = 0;
      do begin
        bus(0, OFS_CSR, 8'h00);
        n++;
      end while (rd[7] !== 1'b1 && n < 400);
      if (rd[7] !== 1'b1) begin
        errCount++;
        stopTest();
      end
      chk(rd, (i == 5) ? 8'hc3 : 8'h83);
      chk(farRx, 8'h96 ^ i[7:0]);
      bus(0, OFS_DATA, 8'h00);
      chk(rd, 8'h3c + i[7:0]);
      bus(0, OFS_CSR, 8'h00);
      chk(rd, 8'h03);
      farSelN <= 1'b1;
    end
    bus(1, OFS_CSR, 8'h07);
    chk(mosiOe, 1'b0);
    bus(1, OFS_CSR, 8'h03);
    chk(mosiOe, 1'b1);
  endtask

  task automatic masterFault();
    bus(1, OFS_CSR, 8'h00);
    bus(1, OFS_CTRL, 8'hd0);
    chk(portEnable, 1'b1);
    selectInN <= 1'b0;
    repeat (4) @(posedge clock);
    chk(portEnable, 1'b0);
    chk(irqRequest, 1'b1);
    bus(0, OFS_CSR, 8'h00);
    chk(rd, 8'h10);
    bus(0, OFS_CTRL, 8'h00);
    chk(rd, 8'h80);
    selectInN <= 1'b1;
    bus(1, OFS_CTRL, 8'h00);
    bus(0, OFS_CSR, 8'h00);
    chk(rd, 8'h00);
  endtask

  task automatic slaveEvents();
    bus(1, OFS_CSR, 8'h03);
    bus(1, OFS_CTRL, 8'hc0);
    bus(1, OFS_DATA, 8'hc3);
    bus(1, OFS_CSR, 8'h02);
    slvByte(8'h5a);
    chk(rd, 8'hc3);
    chk(irqRequest, 1'b1);
    cpuWait <= 1'b1;
    repeat (3) @(posedge clock);
    chk(wakeFromWait, 1'b1);
    cpuWait <= 1'b0;
    cpuIrqMask <= 1'b1;
    repeat (3) @(posedge clock);
    chk(irqRequest, 1'b0);
    cpuIrqMask <= 1'b0;
    slvByte(8'h99);
    bus(0, OFS_CSR, 8'h00);
    chk(rd, 8'ha2);
    bus(0, OFS_CSR, 8'h00);
    chk(rd, 8'h82);
    bus(0, OFS_DATA, 8'h00);
    cpuHalt <= 1'b1;
    repeat (2) @(posedge clock);
    slvByte(8'h33);
    chk(wakeFromHalt, 1'b1);
    cpuHalt <= 1'b0;
    bus(0, OFS_CSR, 8'h00);
    bus(0, OFS_DATA, 8'h00);
    chk(rd, 8'h33);
    slvByte(8'h00);
    bus(0, OFS_CSR, 8'h00);
    bus(0, OFS_DATA, 8'h00);
    bus(1, OFS_CSR, 8'h00);
    cpuHalt <= 1'b1;
    repeat (2) @(posedge clock);
    selectInN <= 1'b0;
    slvByte(8'h44);
    chk(wakeFromHalt, 1'b0);
    cpuHalt <= 1'b0;
    selectInN <= 1'b1;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(0, OFS_CTRL, 8'h00);
    chk(rd, 8'h00);
    bus(0, OFS_CSR, 8'h00);
    chk(rd, 8'h00);
    bus(0, 4'h2, 8'h00);
    chk(rd, 8'h00);
    masterDivs();
    masterFault();
    slaveEvents();
    stopTest();
  end
endmodule

bind spi_ctrl_lowpower spi_ctrl_lowpower_checker
  spi_ctrl_lowpower_checker_inst (.clock, .rst, .read, .write,
  .readdata, .waitrequest, .cpuHalt, .cpuWait, .cpuIrqMask,
  .irqRequest, .wakeFromWait, .wakeFromHalt, .sckOut, .sckOe,
  .mosiOe, .misoOe, .portEnable);
